/* File: hw/main_clk_switch.sv */
`timescale 1ns/100ps
`default_nettype none

module main_clk_switch
   import main_clk_pkg::*;
(
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_SRST,
   input  wire logic       i_INTERNAL_TICK,
   input  wire logic       i_HIGH_SPEED_TICK,
   input  wire logic       i_MAIN_CLK_SELECT,
   input  wire logic       i_INTERNAL_OSC_STOP,
   input  wire logic       i_HIGH_SPEED_SYS_OSC_STOP,
   input  wire logic       i_MODE_CTRL_WR,
   input  wire logic [7:0] i_MODE_CTRL_WDATA,
   input  wire logic       i_STOP_EXEC,
   input  wire logic       i_WAKE,
   output logic            o_CPU_TICK,
   output logic            o_PERIPH_TICK,
   output logic [7:0]      o_SYSTEM_CLOCK_CONTROL,
   output logic [7:0]      o_CLOCK_OP_MODE_CONTROL,
   output logic            o_INTERNAL_OSC_ENABLE,
   output logic            o_HIGH_SPEED_OSC_ENABLE,
   output logic            o_EXT_CLOCK_INPUT_ENABLE,
   output logic            o_STOP_MODE
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      switch_state_type st;
      logic             src;      // active source, drives status
      logic             tgt;      // source being switched to
      logic             cpu_tick;
      logic             per_tick;
      logic             ih_en;
      logic             mx_en;
      logic             ext_en;
      logic             stop;
      logic [7:0]       mode;
   } clk_state_type;

   clk_state_type state_q;
   clk_state_type state_d;

   logic [7:0] mode_value;

   // tick of either source by its code
   function automatic logic pick_tick(input logic s, input logic ih, input logic mx);
      pick_tick = (s == SRC_HIGH_SPEED) ? mx : ih;
   endfunction : pick_tick

   // ---------------------------------------------------------------
   // write-once mode byte
   // ---------------------------------------------------------------
   mode_ctrl_once u_mode
   (
      .i_clk    (I_SYS_CLK),
      .i_srst   (I_SRST),
      .i_wr     (i_MODE_CTRL_WR),
      .i_wdata  (i_MODE_CTRL_WDATA),
      .o_value  (mode_value),
      .o_locked ()
   );

   logic old_tick;
   logic new_tick;
   assign old_tick = pick_tick(state_q.src, i_INTERNAL_TICK, i_HIGH_SPEED_TICK);
   assign new_tick = pick_tick(state_q.tgt, i_INTERNAL_TICK, i_HIGH_SPEED_TICK);

   // ---------------------------------------------------------------
   // switchover sequencer
   // ---------------------------------------------------------------
   // wait for an old edge, then hand over on the first new edge:
   // no runt pulse, and the wait is at most one old period plus one
   // new period, inside 2 old clocks (faster target) or 2*fold/fnew
   // old clocks rounded (slower target)
   always_comb
   begin
      state_d          = state_q;
      state_d.cpu_tick = 1'b0;
      state_d.mode     = mode_value;
      case (state_q.st)
         ST_RUN:
         begin
            state_d.cpu_tick = old_tick;
            if (i_MAIN_CLK_SELECT != state_q.src)
            begin
               state_d.tgt = i_MAIN_CLK_SELECT;
               state_d.st  = ST_WAIT_OLD;
            end
         end
         ST_WAIT_OLD:
         begin
            state_d.cpu_tick = old_tick;
            if (old_tick)
               state_d.st = ST_WAIT_NEW;
         end
         ST_WAIT_NEW:
         begin
            // gap until first target edge keeps latency inside the bound
            if (new_tick)
            begin
               state_d.cpu_tick = 1'b1;
               state_d.src      = state_q.tgt;
               state_d.st       = ST_RUN;
            end
         end
         default:
         begin
            state_d.st = ST_RUN;
         end
      endcase

      // stop gates the tick; a pending switch keeps advancing during stop
      if (i_STOP_EXEC)
         state_d.stop = 1'b1;
      else if (i_WAKE)
         state_d.stop = 1'b0;
      if (state_d.stop)
         state_d.cpu_tick = 1'b0;
      state_d.per_tick = state_d.cpu_tick;

      // oscillator enables; software keeps the stop-order rules,
      // the source in use ignores its stop request; stop mode still gates it, and a clear COM_PIN_SEL_BIT gates the high-speed one
      state_d.ih_en  = !state_d.stop
                       && (!i_INTERNAL_OSC_STOP || state_q.src == SRC_INTERNAL);
      state_d.mx_en  = !state_d.stop && mode_value[COM_PIN_SEL_BIT]
                       && (!i_HIGH_SPEED_SYS_OSC_STOP
                           || state_q.src == SRC_HIGH_SPEED);
      state_d.ext_en = state_d.mx_en && mode_value[COM_EXT_INPUT_BIT];
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_SRST)
      begin
         state_q.st       <= ST_RUN;
         state_q.src      <= SRC_INTERNAL;
         state_q.tgt      <= SRC_INTERNAL;
         state_q.cpu_tick <= 1'b0;
         state_q.per_tick <= 1'b0;
         state_q.ih_en    <= 1'b1;
         state_q.mx_en    <= 1'b0;
         state_q.ext_en   <= 1'b0;
         state_q.stop     <= 1'b0;
         state_q.mode     <= COM_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb
   begin
      o_SYSTEM_CLOCK_CONTROL                 = SCC_RESET;
      o_SYSTEM_CLOCK_CONTROL[SCC_STATUS_BIT] = state_q.src;
      o_SYSTEM_CLOCK_CONTROL[SCC_SELECT_BIT] = state_q.tgt;
   end

   assign o_CPU_TICK               = state_q.cpu_tick;
   assign o_PERIPH_TICK            = state_q.per_tick;
   assign o_CLOCK_OP_MODE_CONTROL  = state_q.mode;
   assign o_INTERNAL_OSC_ENABLE    = state_q.ih_en;
   assign o_HIGH_SPEED_OSC_ENABLE  = state_q.mx_en;
   assign o_EXT_CLOCK_INPUT_ENABLE = state_q.ext_en;
   assign o_STOP_MODE              = state_q.stop;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SRST);

   sequence s_old_edge;
      state_q.st == ST_WAIT_OLD && old_tick;
   endsequence

   sequence s_new_edge;
      state_q.st == ST_WAIT_NEW && new_tick;
   endsequence

   a_periph_follows_cpu: assert property (
      o_PERIPH_TICK == o_CPU_TICK)
      else $error("peripheral tick differs from cpu tick");

   a_select_starts: assert property (
      state_q.st == ST_RUN && i_MAIN_CLK_SELECT != state_q.src
      |=> state_q.st == ST_WAIT_OLD && state_q.tgt == $past(i_MAIN_CLK_SELECT))
      else $error("select change did not start switchover");

   a_old_keeps_running: assert property (
      state_q.st == ST_WAIT_OLD && old_tick && !i_STOP_EXEC && !state_q.stop
      |=> o_CPU_TICK)
      else $error("old source edge lost during switchover");

   a_old_then_new: assert property (
      s_old_edge |=> state_q.st == ST_WAIT_NEW)
      else $error("no handover wait after old edge");

   a_handover_first: assert property (
      s_new_edge |=> state_q.st == ST_RUN && state_q.src == $past(state_q.tgt))
      else $error("handover missed first target edge");

   a_status_only_done: assert property (
      $changed(state_q.src) |-> $past(state_q.st) == ST_WAIT_NEW && $past(new_tick))
      else $error("status moved before switchover completed");

   // sampled reset keeps the release edge out: the tick register is
   // still being cleared there while the source tick may be high
   a_status_bit_src: assert property (
      state_q.st == ST_RUN && !state_q.stop && !i_STOP_EXEC && !I_SRST
      && i_MAIN_CLK_SELECT == state_q.src
      |=> o_CPU_TICK == pick_tick(o_SYSTEM_CLOCK_CONTROL[SCC_STATUS_BIT],
                                  $past(i_INTERNAL_TICK), $past(i_HIGH_SPEED_TICK)))
      else $error("cpu tick not from reported source");

   a_gap_silent: assert property (
      state_q.st == ST_WAIT_NEW && !new_tick |=> !o_CPU_TICK)
      else $error("tick issued before target edge");

   a_stop_gates: assert property (
      i_STOP_EXEC |=> o_STOP_MODE && !o_CPU_TICK && !o_INTERNAL_OSC_ENABLE)
      else $error("stop did not gate clocks");

   a_active_kept: assert property (
      !state_q.stop && !i_STOP_EXEC && state_q.src == SRC_INTERNAL
      |=> o_INTERNAL_OSC_ENABLE)
      else $error("active internal oscillator was stopped");

endmodule : main_clk_switch

`default_nettype wire

/* File: hw/main_clk_pkg.sv */
package main_clk_pkg;

   // ---------------------------------------------------------------
   // system clock control byte layout
   // ---------------------------------------------------------------
   localparam int unsigned SCC_SELECT_BIT = 4;
   localparam int unsigned SCC_STATUS_BIT = 5;
   localparam logic [7:0]  SCC_RESET      = 8'h00;

   // ---------------------------------------------------------------
   // clock operation mode control byte layout
   // ---------------------------------------------------------------
   localparam int unsigned COM_EXT_INPUT_BIT = 7;
   localparam int unsigned COM_PIN_SEL_BIT   = 6;
   localparam logic [7:0]  COM_RESET         = 8'h00;

   // ---------------------------------------------------------------
   // reset values and switchover figures
   // ---------------------------------------------------------------
   localparam logic        SRC_INTERNAL    = 1'b0;
   localparam logic        SRC_HIGH_SPEED  = 1'b1;
   localparam int unsigned SWITCH_MIN_CLKS = 2;

   // switchover sequencer, one-hot
   typedef enum logic [2:0]
   {
      ST_RUN      = 3'b001,
      ST_WAIT_OLD = 3'b010,
      ST_WAIT_NEW = 3'b100
   } switch_state_type;

endpackage : main_clk_pkg

/* File: hw/mode_ctrl_once.sv */
`timescale 1ns/100ps
`default_nettype none

module mode_ctrl_once
   import main_clk_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_value,
   output logic            o_locked
);

   typedef struct packed
   {
      logic [7:0] value;
      logic       locked;
   } once_type;

   once_type state_q;
   once_type state_d;

   // ---------------------------------------------------------------
   // write-once byte
   // ---------------------------------------------------------------
   // first write after reset lands, every later one is dropped
   always_comb
   begin
      state_d = state_q;
      if (i_wr && !state_q.locked)
      begin
         state_d.value  = i_wdata;
         state_d.locked = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_q.value  <= COM_RESET;
         state_q.locked <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign o_value  = state_q.value;
   assign o_locked = state_q.locked;

   a_once_stable: assert property (
      @(posedge i_clk) disable iff (i_srst)
      state_q.locked |=> (state_q.value == $past(state_q.value)) && state_q.locked)
      else $error("mode control byte changed after first write");

endmodule : mode_ctrl_once

`default_nettype wire

/* File: sim/test_main_clk_switch.sv */
`timescale 1ns/100ps
`default_nettype none

module test_main_clk_switch
   import main_clk_pkg::*;
();

   // ---------------------------------------------------------------
   // design signals and bench state
   // ---------------------------------------------------------------
   logic        I_SYS_CLK, I_SRST, i_INTERNAL_TICK, i_HIGH_SPEED_TICK;
   logic        i_MAIN_CLK_SELECT, i_INTERNAL_OSC_STOP, i_HIGH_SPEED_SYS_OSC_STOP;
   logic        i_MODE_CTRL_WR, i_STOP_EXEC, i_WAKE;
   logic [7:0]  i_MODE_CTRL_WDATA;
   logic        o_CPU_TICK, o_PERIPH_TICK, o_INTERNAL_OSC_ENABLE;
   logic        o_HIGH_SPEED_OSC_ENABLE, o_EXT_CLOCK_INPUT_ENABLE, o_STOP_MODE;
   logic [7:0]  o_SYSTEM_CLOCK_CONTROL, o_CLOCK_OP_MODE_CONTROL;
   int          mismatches = 0;
   int          checks     = 0;
   int          mstate;
   logic [31:0] rnd = 32'hD561;
   logic [3:0]  imask, hmask;
   logic        quiet, tgt, stat, tick, locked, ien, hen, xen, stp, old_t, new_t;
   logic [7:0]  mode_int, mode_out;

   main_clk_switch i_main_clk_switch
   (
      .I_SYS_CLK                 (I_SYS_CLK),
      .I_SRST                    (I_SRST),
      .i_INTERNAL_TICK           (i_INTERNAL_TICK),
      .i_HIGH_SPEED_TICK         (i_HIGH_SPEED_TICK),
      .i_MAIN_CLK_SELECT         (i_MAIN_CLK_SELECT),
      .i_INTERNAL_OSC_STOP       (i_INTERNAL_OSC_STOP),
      .i_HIGH_SPEED_SYS_OSC_STOP (i_HIGH_SPEED_SYS_OSC_STOP),
      .i_MODE_CTRL_WR            (i_MODE_CTRL_WR),
      .i_MODE_CTRL_WDATA         (i_MODE_CTRL_WDATA),
      .i_STOP_EXEC               (i_STOP_EXEC),
      .i_WAKE                    (i_WAKE),
      .o_CPU_TICK                (o_CPU_TICK),
      .o_PERIPH_TICK             (o_PERIPH_TICK),
      .o_SYSTEM_CLOCK_CONTROL    (o_SYSTEM_CLOCK_CONTROL),
      .o_CLOCK_OP_MODE_CONTROL   (o_CLOCK_OP_MODE_CONTROL),
      .o_INTERNAL_OSC_ENABLE     (o_INTERNAL_OSC_ENABLE),
      .o_HIGH_SPEED_OSC_ENABLE   (o_HIGH_SPEED_OSC_ENABLE),
      .o_EXT_CLOCK_INPUT_ENABLE  (o_EXT_CLOCK_INPUT_ENABLE),
      .o_STOP_MODE               (o_STOP_MODE)
   );

   // free-running system clock, 8 ns
   initial
   begin
      I_SYS_CLK = 1'b0;
      forever #4 I_SYS_CLK = ~I_SYS_CLK;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask : check

   task finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task step(input int n);
      repeat (n) @(posedge I_SYS_CLK);
   endtask : step

   task write_mode(input logic [7:0] d);
      @(posedge I_SYS_CLK);
      i_MODE_CTRL_WR    <= 1'b1;
      i_MODE_CTRL_WDATA <= d;
      @(posedge I_SYS_CLK);
      i_MODE_CTRL_WR    <= 1'b0;
   endtask : write_mode

   task pulse_stop(input logic e, input logic w);
      @(posedge I_SYS_CLK);
      i_STOP_EXEC <= e;
      i_WAKE      <= w;
      @(posedge I_SYS_CLK);
      i_STOP_EXEC <= 1'b0;
      i_WAKE      <= 1'b0;
      step(3);
   endtask : pulse_stop

   // bounded wait for the status bit; a hang ends the run
   task wait_stat(input logic v);
      for (int i = 0; i < 600; i++)
      begin
         @(negedge I_SYS_CLK);
         if (o_SYSTEM_CLOCK_CONTROL[SCC_STATUS_BIT] === v)
            break;
         if (i == 599)
         begin
            mismatches++;
            $display("mismatch at %0t: status never settled", $time);
            finish_test();
         end
      end
   endtask : wait_stat

   task switch_to(input logic v);
      @(posedge I_SYS_CLK);
      i_MAIN_CLK_SELECT <= v;
      wait_stat(v);
      step(10);
   endtask : switch_to

   // ---------------------------------------------------------------
   // random source ticks; held quiet around stop mode edges
   // ---------------------------------------------------------------
   always @(posedge I_SYS_CLK)
   begin
      rnd = lfsr(rnd);
      i_INTERNAL_TICK   <= !quiet && ((rnd[3:0] & imask) == 4'h0);
      i_HIGH_SPEED_TICK <= !quiet && ((rnd[7:4] & hmask) == 4'h0);
   end

   // ---------------------------------------------------------------
   // reference model, sampled on the same edge as the design
   // ---------------------------------------------------------------
   always @(posedge I_SYS_CLK)
   begin
      old_t = stat ? i_HIGH_SPEED_TICK : i_INTERNAL_TICK;
      new_t = tgt ? i_HIGH_SPEED_TICK : i_INTERNAL_TICK;
      if (I_SRST)
      begin
         {mstate, tgt, stat, tick, locked, hen, xen, stp} = '0;
         {mode_int, mode_out} = {COM_RESET, COM_RESET};
         ien = 1'b1;
      end
      else
      begin
         // stop mode gates ticks and enables in the same cycle it starts
         stp = i_STOP_EXEC ? 1'b1 : (i_WAKE ? 1'b0 : stp);
         // a stop request on the active source is ignored
         ien = !(i_INTERNAL_OSC_STOP && stat) && !stp;
         hen = mode_int[COM_PIN_SEL_BIT] && !(i_HIGH_SPEED_SYS_OSC_STOP && !stat) && !stp;
         xen = hen && mode_int[COM_EXT_INPUT_BIT];
         tick = (mstate == 2 ? new_t : old_t) && !stp;
         case (mstate)
            0: if (i_MAIN_CLK_SELECT != stat) {mstate, tgt} = {32'd1, i_MAIN_CLK_SELECT};
            1: if (old_t) mstate = 2;
            default: if (new_t) {mstate, stat} = {32'd0, tgt};
         endcase
         mode_out = mode_int;
         if (i_MODE_CTRL_WR && !locked)
            {mode_int, locked} = {i_MODE_CTRL_WDATA, 1'b1};
      end
   end

   // compare every output once the edge has settled
   always @(negedge I_SYS_CLK)
   begin
      check(o_CPU_TICK, tick);
      check(o_PERIPH_TICK, tick);
      check(o_SYSTEM_CLOCK_CONTROL, {2'h0, stat, tgt, 4'h0});
      check(o_CLOCK_OP_MODE_CONTROL, mode_out);
      check({o_INTERNAL_OSC_ENABLE, o_HIGH_SPEED_OSC_ENABLE}, {ien, hen});
      check(o_EXT_CLOCK_INPUT_ENABLE, xen);
      check(o_STOP_MODE, stp);
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {i_MAIN_CLK_SELECT, i_INTERNAL_OSC_STOP, i_HIGH_SPEED_SYS_OSC_STOP} = 3'h0;
      {i_MODE_CTRL_WR, i_STOP_EXEC, i_WAKE, quiet} = 4'h0;
      {i_INTERNAL_TICK, i_HIGH_SPEED_TICK, i_MODE_CTRL_WDATA} = 10'h000;
      {imask, hmask} = {4'h0, 4'h3};
      I_SRST = 1'b1;
      step(4);
      I_SRST <= 1'b0;
      // pin setup before the switch; the later write must not land
      write_mode(8'h40);
      step(5);
      write_mode(8'hFF);
      switch_to(1'b1);
      $display("test crystal switch done");
      {i_INTERNAL_OSC_STOP, i_HIGH_SPEED_SYS_OSC_STOP} <= 2'b11;
      step(20);
      {i_INTERNAL_OSC_STOP, i_HIGH_SPEED_SYS_OSC_STOP} <= 2'b00;
      step(10);
      // new source slower than old; select flips back mid-switch
      {imask, hmask} = {4'h7, 4'h0};
      @(posedge I_SYS_CLK);
      i_MAIN_CLK_SELECT <= 1'b0;
      step(2);
      i_MAIN_CLK_SELECT <= 1'b1;
      wait_stat(1'b0);
      wait_stat(1'b1);
      switch_to(1'b0);
      i_HIGH_SPEED_SYS_OSC_STOP <= 1'b1;
      step(20);
      i_HIGH_SPEED_SYS_OSC_STOP <= 1'b0;
      $display("test switch back done");
      // stop mode, and exec winning over a simultaneous wake
      quiet <= 1'b1;
      pulse_stop(1'b1, 1'b0);
      quiet <= 1'b0;
      step(20);
      quiet <= 1'b1;
      pulse_stop(1'b0, 1'b1);
      pulse_stop(1'b1, 1'b1);
      pulse_stop(1'b0, 1'b1);
      quiet <= 1'b0;
      $display("test stop mode done");
      // second reset, then the external clock input
      I_SRST <= 1'b1;
      step(4);
      I_SRST <= 1'b0;
      write_mode(8'hC0);
      switch_to(1'b1);
      switch_to(1'b0);
      i_HIGH_SPEED_SYS_OSC_STOP <= 1'b1;
      step(20);
      $display("test external input done");
      finish_test();
   end

endmodule : test_main_clk_switch

`default_nettype wire
